/* File: shared/msps_pkg.sv */
// Constants for the multi-speed preset selector.
// Assumes a single 250 MHz system clock; frequencies are in 0.01 Hz units.
package msps_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int DET_UNIT_MS = 10;
    localparam int DET_UNIT_CYC = DET_UNIT_MS * 1000 * CLK_MHZ;
    localparam int RAMP_TICK_US = 1000;
    localparam int RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;
    localparam logic [7:0] DET_TIME_MAX = 8'hc8;
    localparam logic [7:0] DET_TIME_RST = 8'h00;

    // ------------------------------------------------------------------
    // Terminals, presets and frequency limits
    // ------------------------------------------------------------------
    localparam int NUM_TERM = 7;
    localparam int NUM_PRESET = 16;
    localparam int NUM_BIN_SEL = 4;
    localparam int NUM_BIT_SEL = 7;
    localparam logic [7:0] FUNC_BIN_BIT0 = 8'h02;
    localparam logic [7:0] FUNC_BITSEL_IN1 = 8'h20;
    localparam logic [15:0] FREQ_MAX = 16'h9c40;
    localparam logic [15:0] PRESET_ZERO_RST = 16'h0258;
    localparam logic [15:0] PRESET_OTHER_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Setting codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_BINARY = 2'h0;
    localparam logic [1:0] MODE_BIT = 2'h1;
    localparam logic [1:0] SRC_STORED = 2'h2;

    typedef enum logic [1:0] {
        MSPS_HOLD,
        MSPS_UP,
        MSPS_DOWN
    } msps_ramp_type;
endpackage

/* File: shared/msps_sel_if.sv */
// Carrier between the select decoder and the preset core.
// Assumes both ends sit on sys_clk_i.
`timescale 1ns/10ps
interface msps_sel_if;
    logic [3:0] applied_idx;
    logic settle_busy;

    modport sel (
        output applied_idx,
        output settle_busy
    );
    modport core (
        input applied_idx,
        input settle_busy
    );
endinterface

/* File: hw/msps_sel.sv */
// Select-input decoder: synchroniser, function map, mode decode, settle timer.
// Assumes terminal pins are asynchronous and settings are sys_clk_i driven.
`timescale 1ns/10ps
module msps_sel #(
    parameter int UNIT_CYC = msps_pkg::DET_UNIT_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Terminals and settings
    input wire logic [msps_pkg::NUM_TERM-1:0] term_i,
    input wire logic [msps_pkg::NUM_TERM-1:0][7:0] term_func_i,
    input wire logic [1:0] sel_mode_i,
    input wire logic [7:0] det_time_i,
    // Result
    msps_sel_if.sel sel
);
    // ------------------------------------------------------------------
    // Synchroniser and function map
    // ------------------------------------------------------------------
    logic [msps_pkg::NUM_TERM-1:0] meta_r;
    logic [msps_pkg::NUM_TERM-1:0] sync_r;
    logic [msps_pkg::NUM_TERM-1:0][msps_pkg::NUM_BIN_SEL-1:0] bin_hit;
    logic [msps_pkg::NUM_TERM-1:0][msps_pkg::NUM_BIT_SEL-1:0] bit_hit;
    logic [msps_pkg::NUM_BIN_SEL-1:0] bin_sel;
    logic [msps_pkg::NUM_BIT_SEL-1:0] bit_sel;

    always_ff @(posedge sys_clk_i) begin
        meta_r <= term_i;
        sync_r <= meta_r;
    end

    for (genvar t = 0; t < msps_pkg::NUM_TERM; t++) begin : g_term
        for (genvar b = 0; b < msps_pkg::NUM_BIN_SEL; b++) begin : g_bin
            assign bin_hit[t][b] = sync_r[t] &&
                term_func_i[t] == msps_pkg::FUNC_BIN_BIT0 + 8'(b);
        end
        for (genvar s = 0; s < msps_pkg::NUM_BIT_SEL; s++) begin : g_bit
            assign bit_hit[t][s] = sync_r[t] &&
                term_func_i[t] == msps_pkg::FUNC_BITSEL_IN1 + 8'(s);
        end
    end

    always_comb begin
        bin_sel = '0;
        bit_sel = '0;
        for (int t = 0; t < msps_pkg::NUM_TERM; t++) begin
            bin_sel = bin_sel | bin_hit[t];
            bit_sel = bit_sel | bit_hit[t];
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic [3:0] bit_idx;
    logic [3:0] raw_idx;

    always_comb begin
        bit_idx = 4'h0;
        // Downward scan so the lowest active input wins
        for (int s = msps_pkg::NUM_BIT_SEL - 1; s >= 0; s--) begin
            if (bit_sel[s]) begin
                bit_idx = 4'(s + 1);
            end
        end
    end

    // Codes other than bit mode fall back to binary
    assign raw_idx = (sel_mode_i == msps_pkg::MODE_BIT) ? bit_idx
                                                        : bin_sel;

    // ------------------------------------------------------------------
    // Determination timer
    // ------------------------------------------------------------------
    logic [3:0] cand_r;
    logic [3:0] applied_r;
    logic [31:0] cyc_r;
    logic [7:0] units_r;
    logic unit_done;
    logic changed;
    logic settled;

    assign changed = raw_idx != cand_r;
    assign unit_done = cyc_r == 32'(UNIT_CYC - 1);
    assign settled = !changed && units_r >= det_time_i;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cand_r <= 4'h0;
            applied_r <= 4'h0;
            cyc_r <= '0;
            units_r <= 8'h00;
        end else if (changed) begin
            cand_r <= raw_idx;
            cyc_r <= '0;
            units_r <= 8'h00;
        end else if (settled) begin
            applied_r <= cand_r;
        end else begin
            cyc_r <= unit_done ? '0 : cyc_r + 32'h1;
            units_r <= unit_done ? units_r + 8'h01 : units_r;
        end
    end

    assign sel.applied_idx = applied_r;
    assign sel.settle_busy = !settled;
endmodule // msps_sel

/* File: hw/msps_top.sv */
// Multi-speed preset selector: preset store, reference choice and ramp.
// Assumes settings and preset writes come from logic on sys_clk_i.
//
// Operation
// - Sixteen motor-one presets are stored and the selected one drives the reference.
// - A change of preset is reached by ramping with the active accel or decel step.
// - Only preset zero has a second-motor copy; presets one to fifteen are motor one only.
// - Mode code 00, the default, selects binary mode with four inputs for sixteen presets.
// - Mode code 01 selects bit mode with seven inputs for eight presets.
// - Both preset zeros take 0.00 or start frequency to 400 Hz and reset to 6.00 Hz.
// - Presets one to fifteen take 0.00 or start frequency to 400 Hz and reset to 0.00 Hz.
// - A determination time of 0 to 200 tens of ms, default 0, masks input changes; det_time_i is not clamped, so up to 255 is used.
// - In binary mode input one is index bit 0 and input four is bit 3.
// - In bit mode the lowest active input n selects preset n, none active selects 0.
// - Selection zero uses the stored preset only when the source is the stored setting.
// - Terminal function codes 02 to 05 assign binary select bits 0 to 3.
// - Terminal function codes 32 to 38 assign the seven bit-mode select inputs.
`timescale 1ns/10ps
module msps_top #(
    parameter int UNIT_CYC = msps_pkg::DET_UNIT_CYC,
    parameter int RAMP_CYC = msps_pkg::RAMP_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Input terminals
    input wire logic [msps_pkg::NUM_TERM-1:0] term_i,
    input wire logic [msps_pkg::NUM_TERM-1:0][7:0] term_func_i,
    // Settings
    input wire logic [1:0] sel_mode_i,
    input wire logic [7:0] det_time_i,
    input wire logic [1:0] freq_src_i,
    input wire logic [15:0] ext_freq_i,
    input wire logic [15:0] start_freq_i,
    input wire logic motor2_sel_i,
    input wire logic [15:0] accel_step_i,
    input wire logic [15:0] decel_step_i,
    // Preset write port
    input wire logic preset_wr_i,
    input wire logic [3:0] preset_idx_i,
    input wire logic preset_motor2_i,
    input wire logic [15:0] preset_data_i,
    // Status and reference
    output logic [3:0] sel_index_o,
    output logic settle_busy_o,
    output logic [15:0] freq_ref_o,
    output logic [15:0] out_freq_o,
    output logic ramp_busy_o
);
    // ------------------------------------------------------------------
    // Select decoder
    // ------------------------------------------------------------------
    msps_sel_if sel_bus();

    msps_sel #(
        .UNIT_CYC(UNIT_CYC)
    ) u_sel (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .term_i(term_i),
        .term_func_i(term_func_i),
        .sel_mode_i(sel_mode_i),
        .det_time_i(det_time_i),
        .sel(sel_bus.sel)
    );

    // ------------------------------------------------------------------
    // Preset store
    // ------------------------------------------------------------------
    logic [15:0] preset_r [msps_pkg::NUM_PRESET];
    logic [15:0] preset_zero_motor2_r;
    logic [15:0] wr_clamped;
    logic wr_m1;
    logic wr_m2;

    // Nonzero values below start frequency are lifted to it
    assign wr_clamped = (preset_data_i > msps_pkg::FREQ_MAX)
                      ? msps_pkg::FREQ_MAX
                      : (preset_data_i != 16'h0000 &&
                         preset_data_i < start_freq_i)
                      ? start_freq_i : preset_data_i;
    // Second-motor writes only land on index zero
    assign wr_m2 = preset_wr_i && preset_motor2_i &&
                   preset_idx_i == 4'h0;
    assign wr_m1 = preset_wr_i && !preset_motor2_i;

    for (genvar p = 0; p < msps_pkg::NUM_PRESET; p++) begin : g_preset
        localparam logic [15:0] RST = (p == 0) ? msps_pkg::PRESET_ZERO_RST
                                               : msps_pkg::PRESET_OTHER_RST;
        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                preset_r[p] <= RST;
            end else if (wr_m1 && preset_idx_i == 4'(p)) begin
                preset_r[p] <= wr_clamped;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            preset_zero_motor2_r <= msps_pkg::PRESET_ZERO_RST;
        end else if (wr_m2) begin
            preset_zero_motor2_r <= wr_clamped;
        end
    end

    // ------------------------------------------------------------------
    // Reference choice
    // ------------------------------------------------------------------
    logic [15:0] zero_ref;
    logic [15:0] target;

    assign zero_ref = (freq_src_i != msps_pkg::SRC_STORED) ? ext_freq_i
                    : motor2_sel_i ? preset_zero_motor2_r
                    : preset_r[0];
    assign target = (sel_bus.applied_idx == 4'h0) ? zero_ref
                  : preset_r[sel_bus.applied_idx];

    // ------------------------------------------------------------------
    // Ramp toward the reference
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic ramp_tick;
    msps_pkg::msps_ramp_type dir;
    logic [16:0] up_sum;
    logic [15:0] up_val;
    logic [15:0] down_val;
    logic [15:0] freq_nxt;

    assign ramp_tick = tick_cnt_r == 32'(RAMP_CYC - 1);
    assign dir = (target > out_freq_o) ? msps_pkg::MSPS_UP
               : (target < out_freq_o) ? msps_pkg::MSPS_DOWN
               : msps_pkg::MSPS_HOLD;
    // Step sizes never overshoot the reference
    assign up_sum = {1'b0, out_freq_o} + {1'b0, accel_step_i};
    assign up_val = (up_sum >= {1'b0, target}) ? target : up_sum[15:0];
    assign down_val = (out_freq_o - target <= decel_step_i)
                    ? target : out_freq_o - decel_step_i;

    always_comb begin
        unique case (dir)
            msps_pkg::MSPS_UP: freq_nxt = up_val;
            msps_pkg::MSPS_DOWN: freq_nxt = down_val;
            msps_pkg::MSPS_HOLD: freq_nxt = out_freq_o;
            default: freq_nxt = out_freq_o;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= ramp_tick ? '0 : tick_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            out_freq_o <= 16'h0000;
            freq_ref_o <= 16'h0000;
            sel_index_o <= 4'h0;
            settle_busy_o <= 1'b0;
            ramp_busy_o <= 1'b0;
        end else begin
            if (ramp_tick) begin
                out_freq_o <= freq_nxt;
            end
            freq_ref_o <= target;
            sel_index_o <= sel_bus.applied_idx;
            settle_busy_o <= sel_bus.settle_busy;
            ramp_busy_o <= dir != msps_pkg::MSPS_HOLD;
        end
    end
endmodule // msps_top

/* File: test/msps_term_model.sv */
// Switch bank driving the select terminals.
// Assumes the bench sets want_i and bounce_i off the clock edge.
`timescale 1ns/10ps
module msps_term_model (
    // Clock
    input wire logic sys_clk_i,
    // Requested combination
    input wire logic [6:0] want_i,
    input wire logic bounce_i,
    // Terminal pins
    output logic [6:0] term_o
);
    // Contacts settle a little after the edge; bounce shows the inverse
    // Few presets use the lowest select inputs first
    initial term_o = 7'h00;
    // Sample at the edge so a same-step bench update cannot race the pins
    always @(posedge sys_clk_i) begin
        term_o <= #1 (bounce_i ? ~want_i : want_i);
    end
endmodule // msps_term_model

/* File: test/msps_top_assertions.sv */
// Checker for the preset selector, bound to msps_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module msps_top_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Inputs watched
    input wire logic [6:0] term_i,
    input wire logic [6:0][7:0] term_func_i,
    input wire logic [1:0] sel_mode_i,
    input wire logic [7:0] det_time_i,
    input wire logic [1:0] freq_src_i,
    input wire logic [15:0] ext_freq_i,
    input wire logic [15:0] accel_step_i,
    input wire logic [15:0] decel_step_i,
    // Outputs watched
    input wire logic [3:0] sel_index_o,
    input wire logic settle_busy_o,
    input wire logic [15:0] freq_ref_o,
    input wire logic [15:0] out_freq_o
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_quiet;
        ($stable(term_i) && $stable(term_func_i) && $stable(sel_mode_i)
            && det_time_i == 8'h00)[*8];
    endsequence
    sequence s_ext_zero;
        (sel_index_o == 4'h0 && freq_src_i != msps_pkg::SRC_STORED
            && $stable(ext_freq_i))[*3];
    endsequence
    property p_idx_hold;
        $changed(sel_index_o) |-> !$past(settle_busy_o);
    endproperty
    property p_quiet;
        s_quiet |-> !settle_busy_o;
    endproperty
    property p_ramp_up;
        out_freq_o > $past(out_freq_o)
            |-> out_freq_o - $past(out_freq_o) <= accel_step_i;
    endproperty
    property p_ramp_dn;
        out_freq_o < $past(out_freq_o)
            |-> $past(out_freq_o) - out_freq_o <= decel_step_i;
    endproperty
    // Reference lags the internal target by one cycle; confirm it one later
    property p_steady;
        out_freq_o == freq_ref_o ##1 $stable(freq_ref_o)
            |-> $stable(out_freq_o);
    endproperty
    property p_rst_ref;
        $fell(reset_i) && freq_src_i == msps_pkg::SRC_STORED
            |-> ##[0:2] freq_ref_o == msps_pkg::PRESET_ZERO_RST;
    endproperty
    property p_ext_zero;
        s_ext_zero |-> freq_ref_o == ext_freq_i;
    endproperty
    property p_ref_max;
        (freq_src_i == msps_pkg::SRC_STORED)[*2]
            |-> freq_ref_o <= msps_pkg::FREQ_MAX;
    endproperty
    a_idx_hold: assert property (p_idx_hold)
        else $error("index moved while settling");
    a_quiet: assert property (p_quiet)
        else $error("settle busy with quiet inputs");
    a_ramp_up: assert property (p_ramp_up)
        else $error("rise exceeds accel step");
    a_ramp_dn: assert property (p_ramp_dn)
        else $error("fall exceeds decel step");
    a_steady: assert property (p_steady)
        else $error("output moved at target");
    a_rst_ref: assert property (p_rst_ref)
        else $error("reset preset zero wrong");
    a_ext_zero: assert property (p_ext_zero)
        else $error("selection zero ignores source");
    a_ref_max: assert property (p_ref_max)
        else $error("reference above maximum");
endmodule // msps_top_chk
bind msps_top msps_top_chk msps_top_chk_i (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .term_i(term_i), .term_func_i(term_func_i),
    .sel_mode_i(sel_mode_i), .det_time_i(det_time_i),
    .freq_src_i(freq_src_i), .ext_freq_i(ext_freq_i),
    .accel_step_i(accel_step_i), .decel_step_i(decel_step_i),
    .sel_index_o(sel_index_o), .settle_busy_o(settle_busy_o),
    .freq_ref_o(freq_ref_o), .out_freq_o(out_freq_o));

/* File: test/tb_top.sv */
// Self-checking bench for the preset selector.
// Assumes short counts: four cycles per settle unit and per ramp tick.
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, m2sel = 1'b0, wr = 1'b0, wm2 = 1'b0;
    logic bounce = 1'b0, busy, rbusy;
    logic [6:0] want = 7'h00, term;
    logic [6:0][7:0] func = '0;
    logic [1:0] mode = 2'h0, src = 2'h2;
    logic [7:0] det = 8'h00;
    logic [3:0] widx = 4'h0, idx;
    logic [15:0] ext = 16'h0000, start = 16'h0000, wdata = 16'h0000;
    logic [15:0] acc = 16'h0064, dec = 16'h00c8, ref_o, outf;
    int errors = 0, compares = 0;
    always #2 clk = ~clk;
    msps_term_model msps_term_model_i (.sys_clk_i(clk), .want_i(want),
        .bounce_i(bounce), .term_o(term));
    msps_top #(.UNIT_CYC(4), .RAMP_CYC(4)) msps_top_i (.sys_clk_i(clk),
        .reset_i(rst), .term_i(term), .term_func_i(func),
        .sel_mode_i(mode), .det_time_i(det), .freq_src_i(src),
        .ext_freq_i(ext), .start_freq_i(start), .motor2_sel_i(m2sel),
        .accel_step_i(acc), .decel_step_i(dec), .preset_wr_i(wr),
        .preset_idx_i(widx), .preset_motor2_i(wm2), .preset_data_i(wdata),
        .sel_index_o(idx), .settle_busy_o(busy), .freq_ref_o(ref_o),
        .out_freq_o(outf), .ramp_busy_o(rbusy));
    // -----
    // Tasks
    // -----
    task automatic stop_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobe stays up between back-to-back writes; caller lowers it
    task automatic wr_p(input logic [3:0] i, input logic m, logic [15:0] d);
        wr = 1'b1;
        widx = i;
        wm2 = m;
        wdata = d;
        tick(1);
    endtask
    task automatic pick(input logic [6:0] v, input int n, input logic [3:0] ei,
                        input logic [15:0] er);
        want = v;
        tick(n);
        chk("index", {12'h000, ei}, {12'h000, idx});
        chk("reference", er, ref_o);
    endtask
    task automatic set_func(input logic [7:0] base, input int cnt);
        func = '0;
        for (int k = 0; k < cnt; k++) func[k] = 8'(k) + base;
    endtask
    task automatic ramp_wait(input logic [15:0] e);
        int k;
        k = 0;
        while (outf !== e && k < 3000) begin
            tick(1);
            k++;
        end
        chk("out_freq", e, outf);
        // Bound used up: the compare above has counted the mismatch
        if (k == 3000) stop_test();
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        set_func(8'h02, 4);
        tick(16);
        rst = 1'b0;
        tick(3);
        chk("reset ref", 16'h0258, ref_o);
        pick(7'h05, 10, 4'h5, 16'h0000);
        // Presets kept under the maximum frequency
        for (int i = 1; i < 16; i++) wr_p(4'(i), 1'b0, 16'(i * 256));
        wr_p(4'h0, 1'b0, 16'h02bc);
        wr = 1'b0;
        for (int i = 0; i < 16; i++)
            pick(7'(i), 10, 4'(i), i == 0 ? 16'h02bc : 16'(i * 256));
        func[0] = 8'h00;
        func[6] = 8'h02;
        pick(7'h40, 10, 4'h1, 16'h0100);
        set_func(8'h02, 4);
        start = 16'h0064;
        wr_p(4'hf, 1'b0, 16'hc350);
        wr_p(4'he, 1'b0, 16'h0032);
        wr_p(4'h0, 1'b1, 16'h04d2);
        wr_p(4'h3, 1'b1, 16'h0001);
        wr = 1'b0;
        pick(7'h0f, 10, 4'hf, 16'h9c40);
        pick(7'h0e, 10, 4'he, 16'h0064);
        m2sel = 1'b1;
        pick(7'h00, 10, 4'h0, 16'h04d2);
        pick(7'h03, 10, 4'h3, 16'h0300);
        m2sel = 1'b0;
        src = 2'h0;
        ext = 16'h08ae;
        pick(7'h00, 10, 4'h0, 16'h08ae);
        src = 2'h2;
        mode = 2'h1;
        set_func(8'h20, 7);
        for (int n = 1; n < 8; n++)
            pick(7'(7'h7f << (n - 1)), 10, 4'(n), 16'(n * 256));
        pick(7'h00, 10, 4'h0, 16'h02bc);
        mode = 2'h0;
        set_func(8'h02, 4);
        pick(7'h01, 10, 4'h1, 16'h0100);
        det = 8'h03;
        bounce = 1'b1;
        tick(6);
        chk("masked index", 16'h0001, {12'h000, idx});
        bounce = 1'b0;
        pick(7'h01, 20, 4'h1, 16'h0100);
        pick(7'h04, 10, 4'h1, 16'h0100);
        chk("settle busy", 16'h0001, {15'h0000, busy});
        pick(7'h04, 20, 4'h4, 16'h0400);
        det = 8'h00;
        ramp_wait(16'h0400);
        pick(7'h08, 10, 4'h8, 16'h0800);
        chk("ramp busy", 16'h0001, {15'h0000, rbusy});
        ramp_wait(16'h0800);
        pick(7'h01, 10, 4'h1, 16'h0100);
        ramp_wait(16'h0100);
        stop_test();
    end
endmodule // tb_top
